//--- design/rcr_map.vh
`ifndef RCR_MAP_VH
`define RCR_MAP_VH

// Register byte offsets.
`define RCR_OFF_FLAGS      12'h000
`define RCR_OFF_CTRL       12'h004
`define RCR_OFF_PC         12'h008
`define RCR_OFF_IRQ_STAT   12'h00C
`define RCR_OFF_IRQ_EN     12'h010
`define RCR_OFF_IRQ_CLR    12'h014
`define RCR_OFF_LOG        12'h018

// Flag register field positions.
`define RCR_B_MEMORY_VIOLATION_FLAG_N         0
`define RCR_B_PD           1
`define RCR_B_TO           2
`define RCR_B_BOR          3
`define RCR_B_POR          4
`define RCR_B_RI           5
`define RCR_B_PIN          6
`define RCR_B_WDT          7
`define RCR_B_UNF          8
`define RCR_B_OVF          9
`define RCR_FLAG_W         10

// Event indices, also interrupt status bit positions.
`define RCR_EV_POR         0
`define RCR_EV_BOR         1
`define RCR_EV_WDT_RST     2
`define RCR_EV_WDT_WAKE    3
`define RCR_EV_INT_WAKE    4
`define RCR_EV_PIN_RUN     5
`define RCR_EV_PIN_SLEEP   6
`define RCR_EV_RESET_INSTR 7
`define RCR_EV_STK_OVF     8
`define RCR_EV_STK_UNF     9
`define RCR_EV_MEMORY_VIOLATION_FLAG_N        10
`define RCR_EV_W           11

// Reset values.
`define RCR_FLAGS_RST      10'h0FF
`define RCR_PC_RST         16'h0000
`define RCR_CTRL_RST       1'h1

`endif

//--- design/rcr_log_mem.v
`include "rcr_map.vh"

module rcr_log_mem #(
    parameter DEPTH = 8,
    parameter AW    = 3,
    parameter DW    = 11
) (
    // Clock.
    input  wire          hclk,
    // Write port.
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [DW-1:0] wr_data,
    // Read port.
    input  wire [AW-1:0] rd_addr,
    output reg  [DW-1:0] rd_data
);

    reg [DW-1:0] mem [0:DEPTH-1];

    // Contents need no reset; the log counter says which entries are valid.
    always @(posedge hclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule

//--- design/rcr_top.v
// How it works
// - Every reset event updates cause bits in the single flag register.
// - Power-on: PC zero, clear power-on and stack flags, set others, brown-out included.
// - Power-on record always has time-out and power-down flags set.
// - Brown-out: PC zero, clear brown-out and stack flags, set pin/instr/TO/PD.
// - Watchdog reset: PC zero, clear watchdog and time-out flags, keep rest.
// - Watchdog wake in sleep: clear time-out and power-down, PC plus one.
// - Interrupt wake: set time-out, clear power-down, keep other flags.
// - Pin reset running: PC zero, clear pin flag, set memory-violation flag.
// - Pin reset asleep: PC zero, clear pin flag, set TO, clear PD.
// - Reset instruction clears its flag, keeps every other flag.
// - Enabled stack overflow resets and sets the overflow flag.
// - Enabled stack underflow resets and sets the underflow flag.
// - Memory violation reset clears the memory-violation flag only.
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`include "rcr_map.vh"

module rcr_top #(
    parameter LOG_DEPTH = 8,
    parameter LOG_AW    = 3
) (
    // Clock and reset.
    input  wire        hclk,
    input  wire        hresetn,
    // AHB-Lite slave.
    input  wire        hsel,
    input  wire [11:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    // Reset and wake sources, one-cycle pulses.
    input  wire        por_event,
    input  wire        brown_out_event,
    input  wire        windowed_watchdog_expire,
    input  wire        interrupt_wake,
    input  wire        external_reset_pin,
    input  wire        asleep,
    input  wire        reset_instr_event,
    input  wire        stack_overflow_event,
    input  wire        stack_underflow_event,
    input  wire        memory_violation_event,
    input  wire [15:0] pc_current,
    // Outputs.
    output reg  [15:0] pc_load_value,
    output reg         pc_load,
    output reg         core_reset,
    output reg         irq,
    output wire        stack_overflow_flag,
    output wire        stack_underflow_flag,
    output wire        watchdog_reset_flag_n,
    output wire        pin_reset_flag_n,
    output wire        reset_instr_flag_n,
    output wire        brown_out_flag_n,
    output wire        time_out_flag_n,
    output wire        power_down_flag_n,
    output wire        memory_violation_flag_n
);

    reg  [`RCR_FLAG_W-1:0] flags_reg;
    reg  [`RCR_FLAG_W-1:0] flags_next;
    reg                    stack_fault_reset_enable_reg;
    reg  [`RCR_EV_W-1:0]   irq_stat_reg;
    reg  [`RCR_EV_W-1:0]   irq_en_reg;
    reg  [LOG_AW:0]        log_cnt_reg;
    reg  [LOG_AW-1:0]      log_wp_reg;
    reg  [LOG_AW-1:0]      log_rd_reg;
    reg  [15:0]            pc_next;
    reg                    pc_load_next;
    reg                    rst_next;
    reg  [`RCR_EV_W-1:0]   ev;
    reg                    dp_wr_reg;
    reg                    dp_rd_reg;
    reg  [11:0]            dp_addr_reg;
    wire [`RCR_EV_W-1:0]   log_rd_data;
    wire                   ap_valid;
    wire                   sw_flag_wr;
    wire                   sw_irq_clr;
    wire                   any_ev;
    wire                   ctrl_wr;
    wire                   irq_en_wr;
    wire                   log_wr;
    reg  [`RCR_EV_W-1:0]   irq_clr_mask;
    reg  [`RCR_EV_W-1:0]   irq_stat_next;
    reg  [LOG_AW:0]        log_cnt_next;
    reg  [LOG_AW-1:0]      log_wp_next;

    // Data-phase register hit; the address was captured during the address phase.
    function rcr_dp_hit;
        input        wr;
        input [11:0] addr;
        input [11:0] off;
        begin
            rcr_dp_hit = wr & (addr == off);
        end
    endfunction

    // Log read word; the memory output lags a read-index write by one cycle.
    function [31:0] rcr_log_word;
        input [LOG_AW:0]      cnt;
        input [LOG_AW-1:0]    idx;
        input [`RCR_EV_W-1:0] vec;
        begin
            rcr_log_word = {4'h0, cnt, 1'b0, idx, 4'h0, vec, 5'h00};
        end
    endfunction

    // Flags other than the power-on flag stay loose outputs too so the core can read them without the bus.
    assign stack_overflow_flag     = flags_reg[`RCR_B_OVF];
    assign stack_underflow_flag    = flags_reg[`RCR_B_UNF];
    assign watchdog_reset_flag_n   = flags_reg[`RCR_B_WDT];
    assign pin_reset_flag_n        = flags_reg[`RCR_B_PIN];
    assign reset_instr_flag_n      = flags_reg[`RCR_B_RI];
    assign brown_out_flag_n        = flags_reg[`RCR_B_BOR];
    assign time_out_flag_n         = flags_reg[`RCR_B_TO];
    assign power_down_flag_n       = flags_reg[`RCR_B_PD];
    assign memory_violation_flag_n = flags_reg[`RCR_B_MEMORY_VIOLATION_FLAG_N];

    // The slave never waits and never errors.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign ap_valid  = hsel & hready & htrans[1];

    // Event vector; stack faults only count while the reset enable is set.
    always @* begin
        ev = {`RCR_EV_W{1'b0}};
        ev[`RCR_EV_POR]         = por_event;
        ev[`RCR_EV_BOR]         = brown_out_event;
        ev[`RCR_EV_WDT_RST]     = windowed_watchdog_expire & ~asleep;
        ev[`RCR_EV_WDT_WAKE]    = windowed_watchdog_expire & asleep;
        ev[`RCR_EV_INT_WAKE]    = interrupt_wake & asleep;
        ev[`RCR_EV_PIN_RUN]     = external_reset_pin & ~asleep;
        ev[`RCR_EV_PIN_SLEEP]   = external_reset_pin & asleep;
        ev[`RCR_EV_RESET_INSTR] = reset_instr_event;
        ev[`RCR_EV_STK_OVF]     = stack_overflow_event & stack_fault_reset_enable_reg;
        ev[`RCR_EV_STK_UNF]     = stack_underflow_event & stack_fault_reset_enable_reg;
        ev[`RCR_EV_MEMORY_VIOLATION_FLAG_N]        = memory_violation_event;
    end

    assign any_ev     = |ev;
    assign sw_flag_wr = rcr_dp_hit(dp_wr_reg, dp_addr_reg, `RCR_OFF_FLAGS);
    assign sw_irq_clr = rcr_dp_hit(dp_wr_reg, dp_addr_reg, `RCR_OFF_IRQ_CLR);
    assign ctrl_wr    = rcr_dp_hit(dp_wr_reg, dp_addr_reg, `RCR_OFF_CTRL);
    assign irq_en_wr  = rcr_dp_hit(dp_wr_reg, dp_addr_reg, `RCR_OFF_IRQ_EN);
    assign log_wr     = rcr_dp_hit(dp_wr_reg, dp_addr_reg, `RCR_OFF_LOG);

    // Interrupt status and log next values; an event beats a same-cycle clear.
    always @* begin
        irq_clr_mask  = sw_irq_clr ? hwdata[`RCR_EV_W-1:0] : {`RCR_EV_W{1'b0}};
        irq_stat_next = (irq_stat_reg & ~irq_clr_mask) | ev;
        log_wp_next   = log_wp_reg;
        log_cnt_next  = log_cnt_reg;
        if (any_ev) begin
            log_wp_next = log_wp_reg + {{(LOG_AW-1){1'b0}}, 1'b1};
            if (log_cnt_reg != LOG_DEPTH) begin
                log_cnt_next = log_cnt_reg + {{LOG_AW{1'b0}}, 1'b1};
            end
        end
    end

    // One event per cycle is taken, highest priority first: power loss beats all.
    // A software write to the flags loses to a same-cycle event in the bits that event sets or clears, and in every bit to power-on.
    always @* begin
        flags_next   = flags_reg;
        pc_next      = pc_load_value;
        pc_load_next = 1'b0;
        rst_next     = 1'b0;
        if (sw_flag_wr) begin
            flags_next = hwdata[`RCR_FLAG_W-1:0];
        end
        if (ev[`RCR_EV_POR]) begin
            flags_next = `RCR_FLAGS_RST;
            flags_next[`RCR_B_POR] = 1'b0;
            pc_next = `RCR_PC_RST;
            pc_load_next = 1'b1;
            rst_next = 1'b1;
        end else if (ev[`RCR_EV_BOR]) begin
            flags_next[`RCR_B_OVF] = 1'b0;
            flags_next[`RCR_B_UNF] = 1'b0;
            flags_next[`RCR_B_BOR] = 1'b0;
            flags_next[`RCR_B_PIN] = 1'b1;
            flags_next[`RCR_B_RI]  = 1'b1;
            flags_next[`RCR_B_TO]  = 1'b1;
            flags_next[`RCR_B_PD]  = 1'b1;
            pc_next = `RCR_PC_RST;
            pc_load_next = 1'b1;
            rst_next = 1'b1;
        end else if (ev[`RCR_EV_WDT_RST]) begin
            flags_next[`RCR_B_WDT] = 1'b0;
            flags_next[`RCR_B_TO]  = 1'b0;
            pc_next = `RCR_PC_RST;
            pc_load_next = 1'b1;
            rst_next = 1'b1;
        end else if (ev[`RCR_EV_WDT_WAKE]) begin
            flags_next[`RCR_B_TO] = 1'b0;
            flags_next[`RCR_B_PD] = 1'b0;
            pc_next = pc_current + 16'h0001;
            pc_load_next = 1'b1;
        end else if (ev[`RCR_EV_PIN_SLEEP]) begin
            flags_next[`RCR_B_PIN] = 1'b0;
            flags_next[`RCR_B_TO]  = 1'b1;
            flags_next[`RCR_B_PD]  = 1'b0;
            pc_next = `RCR_PC_RST;
            pc_load_next = 1'b1;
            rst_next = 1'b1;
        end else if (ev[`RCR_EV_PIN_RUN]) begin
            flags_next[`RCR_B_PIN]  = 1'b0;
            flags_next[`RCR_B_MEMORY_VIOLATION_FLAG_N] = 1'b1;
            pc_next = `RCR_PC_RST;
            pc_load_next = 1'b1;
            rst_next = 1'b1;
        end else if (ev[`RCR_EV_INT_WAKE]) begin
            flags_next[`RCR_B_TO] = 1'b1;
            flags_next[`RCR_B_PD] = 1'b0;
        end else if (ev[`RCR_EV_STK_OVF]) begin
            flags_next[`RCR_B_OVF] = 1'b1;
            pc_next = `RCR_PC_RST;
            pc_load_next = 1'b1;
            rst_next = 1'b1;
        end else if (ev[`RCR_EV_STK_UNF]) begin
            flags_next[`RCR_B_UNF] = 1'b1;
            pc_next = `RCR_PC_RST;
            pc_load_next = 1'b1;
            rst_next = 1'b1;
        end else if (ev[`RCR_EV_MEMORY_VIOLATION_FLAG_N]) begin
            flags_next[`RCR_B_MEMORY_VIOLATION_FLAG_N] = 1'b0;
            pc_next = `RCR_PC_RST;
            pc_load_next = 1'b1;
            rst_next = 1'b1;
        end else if (ev[`RCR_EV_RESET_INSTR]) begin
            flags_next[`RCR_B_RI] = 1'b0;
            pc_next = `RCR_PC_RST;
            pc_load_next = 1'b1;
            rst_next = 1'b1;
        end
    end

    // Cause flags.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_reg <= `RCR_FLAGS_RST;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // Program-counter load and core reset; the pulses last one cycle, the value holds.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_load_value <= `RCR_PC_RST;
            pc_load       <= 1'b0;
            core_reset    <= 1'b0;
        end else begin
            pc_load_value <= pc_next;
            pc_load       <= pc_load_next;
            core_reset    <= rst_next;
        end
    end

    // Bus data phase capture.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_reg   <= 1'b0;
            dp_rd_reg   <= 1'b0;
            dp_addr_reg <= 12'h000;
        end else begin
            dp_wr_reg   <= ap_valid & hwrite;
            dp_rd_reg   <= ap_valid & ~hwrite;
            dp_addr_reg <= haddr;
        end
    end

    // Stack-fault reset enable.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stack_fault_reset_enable_reg <= `RCR_CTRL_RST;
        end else if (ctrl_wr) begin
            stack_fault_reset_enable_reg <= hwdata[0];
        end
    end

    // Interrupt status, enable and line; the line follows the next status, so it rises
    // together with the status bit, while an enable write shows one cycle later.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_reg <= {`RCR_EV_W{1'b0}};
            irq_en_reg   <= {`RCR_EV_W{1'b0}};
            irq          <= 1'b0;
        end else begin
            if (irq_en_wr) begin
                irq_en_reg <= hwdata[`RCR_EV_W-1:0];
            end
            irq_stat_reg <= irq_stat_next;
            irq          <= |(irq_stat_next & irq_en_reg);
        end
    end

    // Log pointers; the count saturates, so the oldest entries are overwritten silently.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            log_cnt_reg <= {(LOG_AW+1){1'b0}};
            log_wp_reg  <= {LOG_AW{1'b0}};
            log_rd_reg  <= {LOG_AW{1'b0}};
        end else begin
            log_cnt_reg <= log_cnt_next;
            log_wp_reg  <= log_wp_next;
            if (log_wr) begin
                log_rd_reg <= hwdata[LOG_AW-1:0];
            end
        end
    end

    // Event history; the read index is a register so the memory output is ready next cycle.
    rcr_log_mem #(
        .DEPTH   (LOG_DEPTH),
        .AW      (LOG_AW),
        .DW      (`RCR_EV_W)
    ) u_log (
        .hclk    (hclk),
        .wr_en   (any_ev),
        .wr_addr (log_wp_reg),
        .wr_data (ev),
        .rd_addr (log_rd_reg),
        .rd_data (log_rd_data)
    );

    // Read data mux, valid in the data phase; unmapped addresses read zero.
    always @* begin
        hrdata = 32'h00000000;
        if (dp_rd_reg) begin
            case (dp_addr_reg)
                `RCR_OFF_FLAGS:    hrdata[`RCR_FLAG_W-1:0] = flags_reg;
                `RCR_OFF_CTRL:     hrdata[0] = stack_fault_reset_enable_reg;
                `RCR_OFF_PC:       hrdata[15:0] = pc_load_value;
                `RCR_OFF_IRQ_STAT: hrdata[`RCR_EV_W-1:0] = irq_stat_reg;
                `RCR_OFF_IRQ_EN:   hrdata[`RCR_EV_W-1:0] = irq_en_reg;
                `RCR_OFF_LOG:      hrdata = rcr_log_word(log_cnt_reg, log_rd_reg, log_rd_data);
                default:           hrdata = 32'h00000000;
            endcase
        end
    end

endmodule

//--- test/rcr_top_props.sv
module rcr_top_props (
    // Clock and reset.
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus request.
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    // Event sources.
    input wire logic        por_event,
    input wire logic        brown_out_event,
    input wire logic        windowed_watchdog_expire,
    input wire logic        interrupt_wake,
    input wire logic        external_reset_pin,
    input wire logic        asleep,
    input wire logic        reset_instr_event,
    input wire logic        stack_overflow_event,
    input wire logic        stack_underflow_event,
    input wire logic        memory_violation_event,
    input wire logic [15:0] pc_current,
    // Results.
    input wire logic [15:0] pc_load_value,
    input wire logic        pc_load,
    input wire logic        core_reset,
    input wire logic        stack_overflow_flag,
    input wire logic        stack_underflow_flag,
    input wire logic        watchdog_reset_flag_n,
    input wire logic        pin_reset_flag_n,
    input wire logic        reset_instr_flag_n,
    input wire logic        brown_out_flag_n,
    input wire logic        time_out_flag_n,
    input wire logic        power_down_flag_n,
    input wire logic        memory_violation_flag_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // Higher-priority resets mask lower events in the same cycle, so antecedents exclude them.
    wire       top2  = por_event | brown_out_event;
    wire       up3   = top2 | windowed_watchdog_expire;
    wire       wr_a  = hsel & hready & hwrite & htrans[1];
    wire       quiet = ~(up3 | interrupt_wake | external_reset_pin | reset_instr_event
                       | stack_overflow_event | stack_underflow_event
                       | memory_violation_event | wr_a);
    wire [8:0] fl    = {stack_overflow_flag, stack_underflow_flag, watchdog_reset_flag_n,
                        pin_reset_flag_n, reset_instr_flag_n, brown_out_flag_n,
                        time_out_flag_n, power_down_flag_n, memory_violation_flag_n};

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_por_record: assert property (por_event |=> fl == 9'h07F)
        else $error("power-on record wrong");
    a_por_legal: assert property (
        por_event |=> time_out_flag_n && power_down_flag_n)
        else $error("illegal power-on record");
    a_bor_record: assert property (
        brown_out_event && !por_event |=> fl[8:7] == 2'h0 && fl[5:1] == 5'h1B)
        else $error("brown-out record wrong");
    a_wdt_reset: assert property (
        windowed_watchdog_expire && !asleep && !top2 |=> fl[6] == 1'h0 && fl[2] == 1'h0
        && core_reset && pc_load_value == 16'h0000)
        else $error("watchdog reset wrong");
    a_wdt_wake: assert property (
        windowed_watchdog_expire && asleep && !top2 |=> pc_load && !core_reset
        && fl[2:1] == 2'h0 && pc_load_value == $past(pc_current) + 16'h0001)
        else $error("watchdog wake wrong");
    a_int_wake: assert property (
        interrupt_wake && asleep && !up3 && !external_reset_pin |=> fl[2:1] == 2'h2)
        else $error("interrupt wake wrong");
    a_pin_run: assert property (
        external_reset_pin && !asleep && !up3 |=> !pin_reset_flag_n
        && memory_violation_flag_n && core_reset && pc_load_value == 16'h0000)
        else $error("pin reset running wrong");
    a_pin_sleep: assert property (
        external_reset_pin && asleep && !up3 |=> !pin_reset_flag_n && fl[2:1] == 2'h2)
        else $error("pin reset asleep wrong");
    a_flags_hold: assert property (quiet && $past(quiet) |=> $stable(fl))
        else $error("flags changed without cause");

    c_wdt_wake: cover property (windowed_watchdog_expire && asleep);
    c_pin_sleep: cover property (external_reset_pin && asleep);
    c_int_wake: cover property (interrupt_wake && asleep);
endmodule

bind rcr_top rcr_top_props rcr_top_props_i (.*);

//--- test/rcr_top_tb.sv
module rcr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, asleep = 1'h0;
    logic        hreadyout, hresp, pc_load, core_reset, irq;
    wire         hready = hreadyout;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata, d;
    logic        por_event = 1'h0, brown_out_event = 1'h0, windowed_watchdog_expire = 1'h0;
    logic        interrupt_wake = 1'h0, external_reset_pin = 1'h0, reset_instr_event = 1'h0;
    logic        stack_overflow_event = 1'h0, stack_underflow_event = 1'h0;
    logic        memory_violation_event = 1'h0;
    logic [15:0] pc_current = 16'h0000, pc_load_value;
    logic        stack_overflow_flag, stack_underflow_flag, watchdog_reset_flag_n;
    logic        pin_reset_flag_n, reset_instr_flag_n, brown_out_flag_n, time_out_flag_n;
    logic        power_down_flag_n, memory_violation_flag_n;
    logic [9:0]  f = 10'h0FF;
    int          err_count = 0, cmp_count = 0;

    rcr_top rcr_top_i (.*);

    initial begin
        forever #20 hclk = ~hclk;
    end

    task automatic summarize;
        if (err_count == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    // Samples ahead of the edge so the slave's own edge update cannot race the capture.
    task automatic wt;
        logic ok;
        for (int i = 0; i < 16; i++) begin
            @(negedge hclk);
            d = hrdata;
            ok = hreadyout;
            @(posedge hclk);
            if (ok === 1'h1) return;
        end
        err_count++;
        summarize();
    endtask

    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] v);
        hsel <= 1'h1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wt();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= v;
        wt();
    endtask

    task automatic rc(input string n, input logic [11:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk(n, e, d);
    endtask

    function automatic logic [9:0] nx(input logic [9:0] v, input int e);
        case (e)
            0: return 10'h0EF;
            1: return (v & 10'h091) | 10'h066;
            2: return v & 10'h37B;
            3: return v & 10'h3F9;
            4: return (v & 10'h3F9) | 10'h004;
            5: return (v & 10'h3BF) | 10'h001;
            6: return (v & 10'h3B9) | 10'h004;
            7: return v & 10'h3DF;
            8: return v | 10'h200;
            9: return v | 10'h100;
            default: return v & 10'h3FE;
        endcase
    endfunction

    task automatic fire(input int e);
        pc_current <= 16'h12F0;
        asleep <= (e == 3 || e == 4 || e == 6);
        case (e)
            0: por_event <= 1'h1;
            1: brown_out_event <= 1'h1;
            2, 3: windowed_watchdog_expire <= 1'h1;
            4: interrupt_wake <= 1'h1;
            5, 6: external_reset_pin <= 1'h1;
            7: reset_instr_event <= 1'h1;
            8: stack_overflow_event <= 1'h1;
            9: stack_underflow_event <= 1'h1;
            default: memory_violation_event <= 1'h1;
        endcase
        @(posedge hclk);
        {por_event, brown_out_event, windowed_watchdog_expire, interrupt_wake, asleep,
         external_reset_pin, reset_instr_event, stack_overflow_event, stack_underflow_event,
         memory_violation_event} <= 10'h000;
        #1;
        chk("core_reset", e != 3 && e != 4, core_reset);
        chk("pc_load", e != 4, pc_load);
        if (e != 4) chk("pc_value", (e == 3) ? 16'h12F1 : 16'h0000, pc_load_value);
        f = nx(f, e);
        @(posedge hclk);
        rc("flags", 12'h000, {22'h0, f});
    endtask

    task automatic t_reset;
        rc("flags", 12'h000, 32'h0FF);
        rc("ctrl", 12'h004, 32'h1);
        rc("irq_en", 12'h010, 32'h0);
    endtask

    task automatic t_chain;
        int ord[11] = '{8, 9, 2, 3, 4, 6, 10, 5, 7, 1, 0};
        fire(0);
        chk("to_pd", 32'h3, {time_out_flag_n, power_down_flag_n});
        bus(1'h1, 12'h018, 32'h0);
        rc("log", 12'h018, 32'h01000020);
        bus(1'h1, 12'h000, 32'h0FF);
        f = 10'h0FF;
        repeat (4) @(posedge hclk);
        rc("held", 12'h000, 32'h0FF);
        foreach (ord[i]) fire(ord[i]);
    endtask

    task automatic t_stack_off;
        bus(1'h1, 12'h004, 32'h0);
        stack_overflow_event <= 1'h1;
        @(posedge hclk);
        stack_overflow_event <= 1'h0;
        #1;
        chk("core_reset", 32'h0, core_reset);
        @(posedge hclk);
        rc("flags", 12'h000, {22'h0, f});
        bus(1'h1, 12'h004, 32'h1);
    endtask

    task automatic t_pc;
        fire(3);
        rc("pc", 12'h008, 32'h12F1);
        fire(4);
        rc("pc_hold", 12'h008, 32'h12F1);
    endtask

    task automatic ck_irq(input logic x);
        repeat (2) @(posedge hclk);
        #1;
        chk("irq", x, irq);
        @(posedge hclk);
    endtask

    task automatic t_irq;
        bus(1'h1, 12'h014, 32'h7FF);
        bus(1'h1, 12'h010, 32'h80);
        fire(10);
        ck_irq(1'h0);
        fire(7);
        ck_irq(1'h1);
        rc("irq_stat", 12'h00C, 32'h480);
        bus(1'h1, 12'h010, 32'h0);
        ck_irq(1'h0);
        bus(1'h1, 12'h014, 32'h80);
        bus(1'h1, 12'h010, 32'h480);
        ck_irq(1'h1);
        bus(1'h1, 12'h014, 32'h400);
        ck_irq(1'h0);
        rc("irq_stat", 12'h00C, 32'h0);
    endtask

    task automatic t_unmapped;
        rc("unmapped", 12'h0FC, 32'h0);
        rc("irq_clr", 12'h014, 32'h0);
        chk("hresp", 32'h0, hresp);
    endtask

    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        t_reset();
        t_chain();
        t_stack_off();
        t_pc();
        t_irq();
        t_unmapped();
        summarize();
    end

    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        summarize();
    end
endmodule
